// *** hw/pbmc_pkg.sv ***
// Shared constants and types of the basic mode control register bank.
// Assumes a single 25 MHz system clock and a serial management interface.
package pbmc_pkg;
  // ===========================================================================
  // Clock and timing
  localparam int CLK_MHZ = 25;
  localparam int CLK_NS = 40;
  localparam int DEAD_TIME_US = 500;
  localparam int DEAD_CYC_DOC = DEAD_TIME_US * CLK_MHZ;
  localparam int SRST_TIME_NS = 1000;
  localparam int SRST_CYC_DOC = (SRST_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int BIT_NS_100 = 10;
  localparam int COL_ON_BT = 512;
  localparam int COL_OFF_BT = 4;
  localparam int COL_ON_CYC = (COL_ON_BT * BIT_NS_100) / CLK_NS;
  localparam int COL_OFF_CYC = (COL_OFF_BT * BIT_NS_100) / CLK_NS;
  localparam int COL_LAT_CYC = 1;
  localparam int BOOT_CYC = 3;
  // ===========================================================================
  // Register map
  localparam logic [4:0] REG_BMC_ADDR = 5'h00;
  localparam logic [4:0] REG_STAT_ADDR = 5'h01;
  localparam logic [4:0] REG_ERRCNT_ADDR = 5'h15;
  localparam int BMC_RESET = 15;
  localparam int BMC_LOOPBACK = 14;
  localparam int BMC_SPEED = 13;
  localparam int BMC_AN_EN = 12;
  localparam int BMC_PWR_DOWN = 11;
  localparam int BMC_ISOLATE = 10;
  localparam int BMC_AN_RESTART = 9;
  localparam int BMC_DUPLEX = 8;
  localparam int BMC_COL_TEST = 7;
  localparam int STAT_AN_DONE = 5;
  localparam int STAT_RFAULT = 4;
  localparam int STAT_LINK = 2;
  localparam int STAT_JABBER = 1;
  localparam logic [15:0] STAT_PERM = 16'h7849;
  localparam logic [15:0] REG_ZERO = 16'h0000;
  localparam logic [7:0] ERRCNT_MAX = 8'hff;
  // ===========================================================================
  // Management frame fields
  localparam logic [1:0] MDIO_OP_RD = 2'h2;
  localparam logic [1:0] MDIO_OP_WR = 2'h1;
  localparam logic [4:0] MDIO_HDR_LAST = 5'h0c;
  localparam logic [4:0] MDIO_DATA_LAST = 5'h0f;
  localparam logic [4:0] MDIO_TA_LAST = 5'h01;

  typedef struct packed {
    logic loopback;
    logic speed_100;
    logic an_enable;
    logic power_down;
    logic isolate;
    logic full_duplex;
    logic col_test;
  } pbmc_ctrl_s;

  localparam pbmc_ctrl_s CTRL_RST = '0;
endpackage

// *** hw/pbmc_mdio_slave.sv ***
// Serial management frame slave: decodes read and write frames on the data pin.
// Assumes mdc_rise is a one-cycle pulse and mdio_in is already synchronised.
`timescale 1ns/1ps
module pbmc_mdio_slave import pbmc_pkg::*; #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic mdc_rise,
  input wire logic mdio_in,
  input wire logic [15:0] rd_data,
  output logic mdio_o,
  output logic mdio_oe,
  output logic [4:0] reg_addr,
  output logic rd_stb,
  output logic wr_stb,
  output logic [15:0] wr_data
);
  typedef enum logic [2:0] {S_IDLE, S_HUNT, S_HDR, S_TA, S_RD, S_WR} pbmc_mdio_e;
  pbmc_mdio_e state_r;
  logic [12:0] hdr_r;
  logic [15:0] sh_r;
  logic [4:0] cnt_r;
  logic is_rd_r;
  logic [12:0] hdr_nxt;

  assign hdr_nxt = {hdr_r[11:0], mdio_in};

  // ===========================================================================
  // Frame sequencer
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= S_IDLE;
      hdr_r <= '0;
      sh_r <= '0;
      cnt_r <= '0;
      is_rd_r <= 1'b0;
      reg_addr <= '0;
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
      rd_stb <= 1'b0;
      wr_stb <= 1'b0;
      wr_data <= '0;
    end else begin
      rd_stb <= 1'b0;
      wr_stb <= 1'b0;
      if (mdc_rise) begin
        case (state_r)
          S_IDLE: if (mdio_in) state_r <= S_HUNT;
          S_HUNT: begin
            if (!mdio_in) begin
              state_r <= S_HDR;
              cnt_r <= '0;
            end
          end
          S_HDR: begin
            hdr_r <= hdr_nxt;
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == MDIO_HDR_LAST) begin
              cnt_r <= '0;
              reg_addr <= hdr_nxt[4:0];
              is_rd_r <= (hdr_nxt[11:10] == MDIO_OP_RD);
              if (hdr_nxt[12] && hdr_nxt[9:5] == PHY_ADDR &&
                  (hdr_nxt[11:10] == MDIO_OP_RD || hdr_nxt[11:10] == MDIO_OP_WR)) begin
                state_r <= S_TA;
              end else begin
                state_r <= S_IDLE;
              end
            end
          end
          S_TA: begin
            cnt_r <= cnt_r + 5'h01;
            if (is_rd_r) begin
              // Data is captured in the same cycle as the read strobe, so a
              // clear-on-read side effect never hides the value being read.
              sh_r <= rd_data;
              rd_stb <= 1'b1;
              mdio_oe <= 1'b1;
              mdio_o <= 1'b0;
              cnt_r <= '0;
              state_r <= S_RD;
            end else if (cnt_r == MDIO_TA_LAST) begin
              cnt_r <= '0;
              state_r <= S_WR;
            end
          end
          S_RD: begin
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == MDIO_DATA_LAST + 5'h01) begin
              mdio_oe <= 1'b0;
              mdio_o <= 1'b0;
              state_r <= S_IDLE;
            end else begin
              mdio_o <= sh_r[15];
              sh_r <= {sh_r[14:0], 1'b0};
            end
          end
          S_WR: begin
            sh_r <= {sh_r[14:0], mdio_in};
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == MDIO_DATA_LAST) begin
              wr_data <= {sh_r[14:0], mdio_in};
              wr_stb <= 1'b1;
              state_r <= S_IDLE;
            end
          end
          default: state_r <= S_IDLE;
        endcase
      end
    end
  end
endmodule // pbmc_mdio_slave

// *** hw/pbmc_mii_path.sv ***
// MII-side data path: loopback, isolation, power down and collision test.
// Assumes the MII transmit inputs are synchronous to clk_sys.
`timescale 1ns/1ps
module pbmc_mii_path import pbmc_pkg::*; #(
  parameter int DEAD_CYC = DEAD_CYC_DOC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire pbmc_ctrl_s ctrl,
  input wire logic mii_tx_en,
  input wire logic [3:0] mii_txd,
  input wire logic pcs_rx_dv,
  input wire logic [3:0] pcs_rxd,
  input wire logic pcs_col,
  output logic mii_rx_dv,
  output logic [3:0] mii_rxd,
  output logic mii_col,
  output logic mii_oe,
  output logic line_tx_en,
  output logic [3:0] line_txd
);
  localparam int DW = $clog2(DEAD_CYC + 1);
  localparam logic [DW-1:0] DEAD_LOAD = DW'(DEAD_CYC);
  logic [DW-1:0] dead_r;
  logic loop_d_r;
  logic off;

  assign off = ctrl.power_down | ctrl.isolate;

  // ===========================================================================
  // Receive dead time after loopback is switched on
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      loop_d_r <= 1'b0;
      dead_r <= '0;
    end else begin
      loop_d_r <= ctrl.loopback;
      if (ctrl.loopback && !loop_d_r) begin
        dead_r <= DEAD_LOAD;
      end else if (dead_r != '0) begin
        dead_r <= dead_r - DW'(1);
      end
    end
  end

  // ===========================================================================
  // Receive outputs, collision and line transmit
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mii_rx_dv <= 1'b0;
      mii_rxd <= '0;
      mii_col <= 1'b0;
      mii_oe <= 1'b0;
      line_tx_en <= 1'b0;
      line_txd <= '0;
    end else begin
      mii_oe <= !ctrl.isolate;
      if (off || (ctrl.loopback && dead_r != '0)) begin
        mii_rx_dv <= 1'b0;
        mii_rxd <= '0;
      end else if (ctrl.loopback) begin
        mii_rx_dv <= mii_tx_en;
        mii_rxd <= mii_txd;
      end else begin
        mii_rx_dv <= pcs_rx_dv;
        mii_rxd <= pcs_rxd;
      end
      // One register stage keeps both collision edges inside 4 bit times.
      mii_col <= !off && ((ctrl.col_test && mii_tx_en) || (!ctrl.loopback && pcs_col));
      line_tx_en <= !off && !ctrl.loopback && mii_tx_en;
      line_txd <= (off || ctrl.loopback) ? 4'h0 : mii_txd;
    end
  end
endmodule // pbmc_mii_path

// *** hw/pbmc_top.sv ***
// Basic mode control register bank of a 10/100 transceiver with its management port.
// Assumes strap and management pins are asynchronous and MII transmit is on clk_sys.
//
// Overview of operation
// - Writing one to bit 15 starts soft reset; it reads one until done.
// - Completing soft reset reloads strap values exactly like a hardware reset.
// - Loopback bit 14 routes MII transmit data onto MII receive outputs.
// - After loopback is enabled, receive outputs may carry no data for 500 us.
// - Bit 13 selects 100 or 10 Mb/s when negotiation is off; strap reset value.
// - Bit 12 negotiation enable comes from strap and is forced zero in fiber mode.
// - Negotiation on ignores bits 8 and 13; off, they set speed and duplex.
// - Power-down bit 11 stops transceiver functions; registers keep working.
// - Isolate bit 10 disconnects the MII; management stays functional.
// - Bit 9 restarts negotiation if enabled, reads one until it begins.
// - Writing zero to bit 9 never disturbs a running negotiation.
// - Bit 8 selects full or half duplex when negotiation is off; strap reset.
// - Collision test raises COL within 512 and drops it within 4 bit times.
// - Latched-high bits hold set until read; latched-low hold clear until read.
// - Clear-on-read fields zero on read, or count one for an error in the read cycle; self-clearing bits follow their event.
// - Permanent read-only fields return fixed values and ignore writes.
`timescale 1ns/1ps
module pbmc_top import pbmc_pkg::*; #(
  parameter logic [4:0] PHY_ADDR = 5'h01,
  parameter int DEAD_CYC = DEAD_CYC_DOC,
  parameter int SRST_CYC = SRST_CYC_DOC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic strap_speed_100,
  input wire logic strap_an_enable,
  input wire logic strap_full_duplex,
  input wire logic fiber_mode_enable,
  input wire logic mii_tx_en,
  input wire logic [3:0] mii_txd,
  output logic mii_rx_dv,
  output logic [3:0] mii_rxd,
  output logic mii_col,
  output logic mii_oe,
  input wire logic pcs_rx_dv,
  input wire logic [3:0] pcs_rxd,
  input wire logic pcs_col,
  output logic line_tx_en,
  output logic [3:0] line_txd,
  input wire logic an_started,
  input wire logic an_complete,
  input wire logic an_speed_100,
  input wire logic an_full_duplex,
  input wire logic link_ok,
  input wire logic jabber_evt,
  input wire logic rfault_evt,
  input wire logic rx_err_evt,
  output logic an_enable,
  output logic an_restart,
  output logic speed_100,
  output logic full_duplex,
  output logic power_down,
  output logic isolate,
  output logic soft_reset_busy
);
  if (DEAD_CYC < 1 || SRST_CYC < 1 || COL_LAT_CYC > COL_OFF_CYC || COL_LAT_CYC > COL_ON_CYC) begin : g_bad_param
    $error("pbmc_top: parameter out of range");
  end

  localparam int SW = $clog2(SRST_CYC + 1);
  localparam logic [SW-1:0] SRST_LAST = SW'(SRST_CYC - 1);
  localparam logic [1:0] BOOT_LAST = 2'(BOOT_CYC - 1);

  // ===========================================================================
  // Pin synchronisers
  logic [1:0] mdc_s_r;
  logic mdc_d_r;
  logic [1:0] mdio_s_r;
  logic [3:0] strap_s1_r;
  logic [3:0] strap_s2_r;
  logic mdc_rise;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mdc_s_r <= '0;
      mdc_d_r <= 1'b0;
      mdio_s_r <= '0;
      strap_s1_r <= '0;
      strap_s2_r <= '0;
    end else begin
      mdc_s_r <= {mdc_s_r[0], mdc};
      mdc_d_r <= mdc_s_r[1];
      mdio_s_r <= {mdio_s_r[0], mdio_i};
      strap_s1_r <= {fiber_mode_enable, strap_speed_100, strap_an_enable, strap_full_duplex};
      strap_s2_r <= strap_s1_r;
    end
  end

  assign mdc_rise = mdc_s_r[1] && !mdc_d_r;

  // ===========================================================================
  // Management frames
  logic [4:0] reg_addr;
  logic rd_stb;
  logic wr_stb;
  logic [15:0] wr_data;
  logic [15:0] rd_data;

  pbmc_mdio_slave #(.PHY_ADDR(PHY_ADDR)) u_mdio (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .mdc_rise(mdc_rise),
    .mdio_in(mdio_s_r[1]),
    .rd_data(rd_data),
    .mdio_o(mdio_o),
    .mdio_oe(mdio_oe),
    .reg_addr(reg_addr),
    .rd_stb(rd_stb),
    .wr_stb(wr_stb),
    .wr_data(wr_data)
  );

  logic wr_bmc;
  logic rd_stat;
  logic rd_errcnt;
  logic fiber;

  assign wr_bmc = wr_stb && reg_addr == REG_BMC_ADDR;
  assign rd_stat = rd_stb && reg_addr == REG_STAT_ADDR;
  assign rd_errcnt = rd_stb && reg_addr == REG_ERRCNT_ADDR;
  assign fiber = strap_s2_r[3];

  // ===========================================================================
  // Strap loading at hardware reset release and at soft reset end
  logic [1:0] boot_cnt_r;
  logic boot_done_r;
  logic [SW-1:0] srst_cnt_r;
  logic srst_busy_r;
  logic srst_done;
  logic strap_load;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      boot_cnt_r <= '0;
      boot_done_r <= 1'b0;
    end else if (!boot_done_r) begin
      boot_cnt_r <= boot_cnt_r + 2'h1;
      boot_done_r <= (boot_cnt_r == BOOT_LAST);
    end
  end

  assign srst_done = srst_busy_r && srst_cnt_r == SRST_LAST;
  assign strap_load = (!boot_done_r && boot_cnt_r == BOOT_LAST) || srst_done;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      srst_busy_r <= 1'b0;
      srst_cnt_r <= '0;
    end else if (srst_busy_r) begin
      srst_cnt_r <= srst_cnt_r + SW'(1);
      if (srst_done) begin
        srst_busy_r <= 1'b0;
      end
    end else if (wr_bmc && wr_data[BMC_RESET]) begin
      srst_busy_r <= 1'b1;
      srst_cnt_r <= '0;
    end
  end

  // ===========================================================================
  // Control fields
  pbmc_ctrl_s ctrl_r;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= CTRL_RST;
    end else if (strap_load) begin
      ctrl_r <= CTRL_RST;
      ctrl_r.speed_100 <= strap_s2_r[2];
      ctrl_r.an_enable <= strap_s2_r[1] && !fiber;
      ctrl_r.full_duplex <= strap_s2_r[0];
    end else if (wr_bmc && !srst_busy_r && !wr_data[BMC_RESET]) begin
      ctrl_r.loopback <= wr_data[BMC_LOOPBACK];
      ctrl_r.speed_100 <= wr_data[BMC_SPEED];
      ctrl_r.an_enable <= wr_data[BMC_AN_EN] && !fiber;
      ctrl_r.power_down <= wr_data[BMC_PWR_DOWN];
      ctrl_r.isolate <= wr_data[BMC_ISOLATE];
      ctrl_r.full_duplex <= wr_data[BMC_DUPLEX];
      ctrl_r.col_test <= wr_data[BMC_COL_TEST];
    end else if (fiber) begin
      ctrl_r.an_enable <= 1'b0;
    end
  end

  // ===========================================================================
  // Auto-negotiation restart
  logic restart_set;
  logic restart_r;

  assign restart_set = wr_bmc && !srst_busy_r && !wr_data[BMC_RESET] &&
                       wr_data[BMC_AN_RESTART] && wr_data[BMC_AN_EN] && !fiber;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      restart_r <= 1'b0;
    end else if (strap_load || !ctrl_r.an_enable && !restart_set) begin
      restart_r <= 1'b0;
    end else if (restart_set) begin
      restart_r <= 1'b1;
    end else if (an_started) begin
      restart_r <= 1'b0;
    end
  end

  // ===========================================================================
  // Status latches and error counter
  logic jabber_r;
  logic rfault_r;
  logic link_r;
  logic [7:0] errcnt_r;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      jabber_r <= 1'b0;
      rfault_r <= 1'b0;
      link_r <= 1'b0;
    end else begin
      jabber_r <= jabber_evt || (jabber_r && !rd_stat);
      rfault_r <= rfault_evt || (rfault_r && !rd_stat);
      if (!link_ok) begin
        link_r <= 1'b0;
      end else if (rd_stat) begin
        link_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      errcnt_r <= '0;
    end else if (rd_errcnt) begin
      errcnt_r <= {7'h00, rx_err_evt};
    end else if (rx_err_evt && errcnt_r != ERRCNT_MAX) begin
      errcnt_r <= errcnt_r + 8'h01;
    end
  end

  // ===========================================================================
  // Read data
  always_comb begin
    rd_data = REG_ZERO;
    case (reg_addr)
      REG_BMC_ADDR: begin
        rd_data[BMC_RESET] = srst_busy_r;
        rd_data[BMC_LOOPBACK] = ctrl_r.loopback;
        rd_data[BMC_SPEED] = ctrl_r.speed_100;
        rd_data[BMC_AN_EN] = ctrl_r.an_enable;
        rd_data[BMC_PWR_DOWN] = ctrl_r.power_down;
        rd_data[BMC_ISOLATE] = ctrl_r.isolate;
        rd_data[BMC_AN_RESTART] = restart_r;
        rd_data[BMC_DUPLEX] = ctrl_r.full_duplex;
        rd_data[BMC_COL_TEST] = ctrl_r.col_test;
      end
      REG_STAT_ADDR: begin
        rd_data = STAT_PERM;
        rd_data[STAT_AN_DONE] = an_complete;
        rd_data[STAT_RFAULT] = rfault_r;
        rd_data[STAT_LINK] = link_r;
        rd_data[STAT_JABBER] = jabber_r;
      end
      REG_ERRCNT_ADDR: rd_data = {8'h00, errcnt_r};
      default: rd_data = REG_ZERO;
    endcase
  end

  // ===========================================================================
  // Mode outputs
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      an_enable <= 1'b0;
      an_restart <= 1'b0;
      speed_100 <= 1'b0;
      full_duplex <= 1'b0;
      power_down <= 1'b0;
      isolate <= 1'b0;
      soft_reset_busy <= 1'b0;
    end else begin
      an_enable <= ctrl_r.an_enable;
      an_restart <= restart_r;
      speed_100 <= ctrl_r.an_enable ? an_speed_100 : ctrl_r.speed_100;
      full_duplex <= ctrl_r.an_enable ? an_full_duplex : ctrl_r.full_duplex;
      power_down <= ctrl_r.power_down;
      isolate <= ctrl_r.isolate;
      soft_reset_busy <= srst_busy_r;
    end
  end

  // ===========================================================================
  // MII path
  pbmc_mii_path #(.DEAD_CYC(DEAD_CYC)) u_mii (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ctrl(ctrl_r),
    .mii_tx_en(mii_tx_en),
    .mii_txd(mii_txd),
    .pcs_rx_dv(pcs_rx_dv),
    .pcs_rxd(pcs_rxd),
    .pcs_col(pcs_col),
    .mii_rx_dv(mii_rx_dv),
    .mii_rxd(mii_rxd),
    .mii_col(mii_col),
    .mii_oe(mii_oe),
    .line_tx_en(line_tx_en),
    .line_txd(line_txd)
  );
endmodule // pbmc_top

// *** verif/pbmc_properties.sv ***
// Concurrent checks on the control, MII and management outputs of pbmc_top.
// Assumes one system clock and the active-low asynchronous reset of the top.
`timescale 1ns/1ps
module pbmc_properties #(
  parameter int SRST_CYC = 25
) (
  input logic clk_sys,
  input logic nrst,
  input logic mdio_o,
  input logic mdio_oe,
  input logic an_started,
  input logic an_speed_100,
  input logic mii_rx_dv,
  input logic mii_col,
  input logic mii_oe,
  input logic line_tx_en,
  input logic an_enable,
  input logic an_restart,
  input logic speed_100,
  input logic power_down,
  input logic isolate,
  input logic soft_reset_busy
);
  // ==========================================================================
  // Soft reset length counter
  int bcnt_r;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bcnt_r <= 0;
    end else begin
      bcnt_r <= soft_reset_busy ? bcnt_r + 1 : 0;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // ==========================================================================
  // Assertions
  AST_SRST_LEN: assert property ($fell(soft_reset_busy) |->
    bcnt_r >= SRST_CYC - 2 && bcnt_r <= SRST_CYC + 1) else $error("soft reset length wrong");
  AST_SRST_DEF: assert property ($fell(soft_reset_busy) |->
    ##[0:4] !isolate && !power_down && !an_restart) else $error("controls not restored");
  AST_PD_QUIET: assert property (power_down && $past(power_down) |->
    !mii_rx_dv && !mii_col && !line_tx_en) else $error("MII active in power down");
  AST_ISO_OFF: assert property (isolate && $past(isolate) |-> !mii_oe) else $error("MII driven while isolated");
  AST_AN_GATE: assert property (an_restart |-> an_enable) else $error("restart without negotiation");
  AST_RESTART_HOLD: assert property ($fell(an_restart) |-> !an_enable || $past(soft_reset_busy) ||
    $past(an_started) || $past(an_started, 2) || $past(an_started, 3)) else $error("restart lost");
  AST_SPEED_AN: assert property (an_enable && $past(an_enable, 3) |->
    speed_100 == an_speed_100) else $error("speed not from negotiation");
  AST_TA_ZERO: assert property ($rose(mdio_oe) |-> !mdio_o) else $error("turnaround bit not zero");
endmodule // pbmc_properties

bind pbmc_top pbmc_properties #(.SRST_CYC(SRST_CYC)) u_props (
  .clk_sys, .nrst, .mdio_o, .mdio_oe, .an_started, .an_speed_100, .mii_rx_dv, .mii_col, .mii_oe,
  .line_tx_en, .an_enable, .an_restart, .speed_100, .power_down, .isolate, .soft_reset_busy
);

// *** verif/pbmc_mac_model.sv ***
// MAC-side management controller: clocks frames on mdc and drives or releases data.
// Assumes the bench resolves the shared data wire with a pull-up.
`timescale 1ns/1ps
module pbmc_mac_model import pbmc_pkg::*; #(
  parameter logic [4:0] PHY = 5'h01
) (
  input logic clk_sys,
  input logic mdio_w,
  output logic mdc,
  output logic mac_oe,
  output logic mac_d
);
  // ==========================================================================
  // Frame engine
  initial begin
    mdc = 1'b0;
    mac_oe = 1'b0;
    mac_d = 1'b0;
  end
  // The clock stands low between frames; a read releases the line from turnaround on.
  task automatic frame(input logic wr, input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [33:0] h;
    int i;
    h = {4'b1101, wr ? MDIO_OP_WR : MDIO_OP_RD, PHY, ra, 2'b10, wd};
    for (i = 33; i >= 0; i--) begin
      mac_oe = wr || i > 17;
      mac_d = h[i];
      repeat (5) @(negedge clk_sys);
      if (i < 16) begin
        rd[i] = mdio_w;
      end
      mdc = 1'b1;
      repeat (5) @(negedge clk_sys);
      mdc = 1'b0;
    end
    mac_oe = 1'b0;
  endtask
endmodule // pbmc_mac_model

// *** verif/pbmc_top_tb_top.sv ***
// Bench top: drives straps, MII, PCS and event inputs, and register frames via the MAC model.
// Assumes the checker binds itself to pbmc_top.
`timescale 1ns/1ps
module pbmc_top_tb_top import pbmc_pkg::*; ;
  localparam int DEAD = 20;
  localparam int SRST = 600;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic mdc, mdio_o, mdio_oe, mac_oe, mac_d, mii_rx_dv, mii_col, mii_oe, line_tx_en;
  logic an_enable, an_restart, speed_100, full_duplex, power_down, isolate, soft_reset_busy;
  logic [3:0] mii_rxd, line_txd;
  logic strap_speed_100, strap_an_enable, strap_full_duplex;
  logic fiber_mode_enable = 1'b0;
  logic mii_tx_en = 1'b0;
  logic [3:0] mii_txd;
  logic pcs_rx_dv = 1'b0;
  logic [3:0] pcs_rxd = 4'h5;
  logic pcs_col = 1'b0;
  logic an_started = 1'b0;
  logic an_complete = 1'b0;
  logic an_speed_100 = 1'b0;
  logic an_full_duplex = 1'b0;
  logic link_ok = 1'b1;
  logic jabber_evt = 1'b0;
  logic rfault_evt = 1'b0;
  logic rx_err_evt = 1'b0;
  wire logic mdio_i = mdio_oe ? mdio_o : (mac_oe ? mac_d : 1'b1);
  logic [15:0] tbl[3] = '{16'h2000, 16'h0100, 16'h2100};
  logic [15:0] q[$];
  logic [15:0] obs;
  event got;
  int fails = 0;
  int n_compared = 0;
  int seed = 56847;
  always #20 clk_sys = ~clk_sys;
  pbmc_mac_model mac (.clk_sys, .mdio_w(mdio_i), .mdc, .mac_oe, .mac_d);
  pbmc_top #(.DEAD_CYC(DEAD), .SRST_CYC(SRST)) DUT (
    .clk_sys, .nrst, .mdc, .mdio_i, .mdio_o, .mdio_oe, .strap_speed_100, .strap_an_enable,
    .strap_full_duplex, .fiber_mode_enable, .mii_tx_en, .mii_txd, .mii_rx_dv, .mii_rxd, .mii_col,
    .mii_oe, .pcs_rx_dv, .pcs_rxd, .pcs_col, .line_tx_en, .line_txd, .an_started, .an_complete,
    .an_speed_100, .an_full_duplex, .link_ok, .jabber_evt, .rfault_evt, .rx_err_evt, .an_enable,
    .an_restart, .speed_100, .full_duplex, .power_down, .isolate, .soft_reset_busy
  );
  // ==========================================================================
  // Scoreboard and helpers
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input logic [15:0] m);
    q.push_back(e & m);
    obs = g & m;
    -> got;
    #1;
  endtask
  task automatic ck(input logic g, input logic e);
    chk({15'h0000, g}, {15'h0000, e}, 16'hffff);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] r;
    mac.frame(1'b1, a, d, r);
    cyc(4);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
    logic [15:0] r;
    mac.frame(1'b0, a, 16'h0000, r);
    chk(r, e, m);
  endtask
  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial forever begin
    @(got);
    n_compared++;
    if (obs !== q[0]) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, obs, q[0]);
    end
    void'(q.pop_front());
  end
  initial begin
    cyc(60000);
    fails++;
    complete_run();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    logic [15:0] r;
    int i;
    {strap_speed_100, strap_an_enable, strap_full_duplex} = 3'($random(seed));
    mii_txd = 4'($random(seed));
    cyc(12);
    nrst = 1'b1;
    cyc(8);
    rdc(REG_BMC_ADDR, {2'b00, strap_speed_100, strap_an_enable, 3'h0, strap_full_duplex, 8'h00}, 16'hffff);
    fiber_mode_enable = 1'b1;
    cyc(8);
    ck(an_enable, 1'b0);
    rdc(REG_BMC_ADDR, 16'h0000, 16'h1000);
    fiber_mode_enable = 1'b0;
    foreach (tbl[i]) begin
      wr(REG_BMC_ADDR, tbl[i]);
      ck(speed_100, tbl[i][13]);
      ck(full_duplex, tbl[i][8]);
    end
    wr(REG_BMC_ADDR, 16'h3300);
    ck(speed_100, 1'b0);
    ck(full_duplex, 1'b0);
    ck(an_restart, 1'b1);
    wr(REG_BMC_ADDR, 16'h3100);
    ck(an_restart, 1'b1);
    rdc(REG_BMC_ADDR, 16'h3300, 16'hffff);
    an_started = 1'b1;
    cyc(1);
    an_started = 1'b0;
    cyc(4);
    ck(an_restart, 1'b0);
    rdc(REG_BMC_ADDR, 16'h3100, 16'hffff);
    wr(REG_BMC_ADDR, 16'h0200);
    ck(an_restart, 1'b0);
    mii_tx_en = 1'b1;
    wr(REG_BMC_ADDR, 16'h4000);
    ck(mii_rx_dv, 1'b0);
    cyc(DEAD + 4);
    ck(mii_rx_dv, 1'b1);
    chk({12'h000, mii_rxd}, {12'h000, mii_txd}, 16'hffff);
    ck(line_tx_en, 1'b0);
    mii_tx_en = 1'b0;
    wr(REG_BMC_ADDR, 16'h0080);
    mii_tx_en = 1'b1;
    cyc(1);
    ck(mii_col, 1'b1);
    chk({12'h000, line_txd}, {12'h000, mii_txd}, 16'hffff);
    mii_tx_en = 1'b0;
    cyc(1);
    ck(mii_col, 1'b0);
    pcs_rx_dv = 1'b1;
    wr(REG_BMC_ADDR, 16'h0800);
    ck(power_down, 1'b1);
    ck(mii_rx_dv, 1'b0);
    rdc(REG_BMC_ADDR, 16'h0800, 16'hffff);
    pcs_rx_dv = 1'b0;
    wr(REG_BMC_ADDR, 16'h0400);
    ck(mii_oe, 1'b0);
    rdc(REG_BMC_ADDR, 16'h0400, 16'hffff);
    {strap_speed_100, strap_an_enable, strap_full_duplex} = 3'($random(seed));
    wr(REG_BMC_ADDR, 16'h8000);
    ck(soft_reset_busy, 1'b1);
    rdc(REG_BMC_ADDR, 16'h8000, 16'h8000);
    cyc(SRST);
    rdc(REG_BMC_ADDR, {2'b00, strap_speed_100, strap_an_enable, 3'h0, strap_full_duplex, 8'h00}, 16'hffff);
    ck(isolate, 1'b0);
    an_complete = 1'b1;
    mac.frame(1'b0, REG_STAT_ADDR, 16'h0000, r);
    rdc(REG_STAT_ADDR, STAT_PERM | 16'h0024, 16'hffff);
    link_ok = 1'b0;
    jabber_evt = 1'b1;
    cyc(1);
    link_ok = 1'b1;
    jabber_evt = 1'b0;
    rdc(REG_STAT_ADDR, STAT_PERM | 16'h0022, 16'hffff);
    wr(REG_STAT_ADDR, 16'h0000);
    rdc(REG_STAT_ADDR, STAT_PERM | 16'h0024, 16'hffff);
    for (i = 0; i < 3; i++) begin
      rx_err_evt = 1'b1;
      cyc(1);
      rx_err_evt = 1'b0;
      cyc(1);
    end
    rdc(REG_ERRCNT_ADDR, 16'h0003, 16'hffff);
    rdc(REG_ERRCNT_ADDR, 16'h0000, 16'hffff);
    rdc(5'h1f, 16'h0000, 16'hffff);
    complete_run();
  end
endmodule // pbmc_top_tb_top
